/* File: pkg/ldc_pkg.sv */
`default_nettype none
package ldc_pkg;
   // register index (word) on the plain port
   localparam logic [1:0] LDC_ADDR_CTRL_MAIN   = 2'h0;
   localparam logic [1:0] LDC_ADDR_LEVEL_SEL   = 2'h1;
   localparam logic [1:0] LDC_ADDR_STATUS      = 2'h2;

   // converter_control_main fields
   localparam int LDC_BIT_ENABLE    = 7;
   localparam int LDC_BIT_LPS       = 6;
   localparam int LDC_BIT_PIN_OE    = 5;
   localparam int LDC_BIT_PSS_HI    = 3;
   localparam int LDC_BIT_PSS_LO    = 2;
   localparam logic [7:0] LDC_MAIN_MASK  = 8'hec;
   localparam logic [7:0] LDC_LEVEL_MASK = 8'h1f;
   localparam logic [7:0] LDC_MAIN_RST   = 8'h00;
   localparam logic [7:0] LDC_LEVEL_RST  = 8'h00;

   localparam int LDC_LEVEL_W = 5;
   localparam int LDC_LEVELS  = 32;
   localparam logic [4:0] LDC_CODE_TOP = 5'h1f;
   localparam logic [4:0] LDC_CODE_BOT = 5'h00;

   // positive_source_select encodings
   localparam logic [1:0] LDC_PSS_SUPPLY   = 2'h0;
   localparam logic [1:0] LDC_PSS_EXT_REF  = 2'h1;
   localparam logic [1:0] LDC_PSS_FIXED    = 2'h2;
   localparam logic [1:0] LDC_PSS_RESERVED = 2'h3;

   typedef enum logic [1:0] {
      LDC_MODE_OFF       = 2'h0,
      LDC_MODE_LADDER    = 2'h1,
      LDC_MODE_CLAMP_POS = 2'h3,
      LDC_MODE_CLAMP_NEG = 2'h2
   } ldc_mode_type;

   typedef struct packed {
      logic       converter_enable;
      logic       low_power_source_select;
      logic       pin_output_enable;
      logic [1:0] positive_source_select;
      logic [4:0] level_code;
   } ldc_cfg_type;

   typedef struct packed {
      logic       src_pos_connect;
      logic       src_neg_connect;
      logic       sel_supply;
      logic       sel_ext_ref;
      logic       sel_fixed_reference;
      logic [31:0] tap_onehot;
      ldc_mode_type mode;
   } ldc_ladder_type;

   typedef struct packed {
      logic route_to_pin;
      logic dig_drv_off;
      logic dig_in_off;
   } ldc_pin_type;
endpackage : ldc_pkg
`default_nettype wire

/* File: hw/ldc_tap_decode.sv */
`default_nettype none
module ldc_tap_decode
   import ldc_pkg::*;
(
   input  wire logic [4:0]  code,
   input  wire logic        active,
   output logic      [31:0] tap
);
   // one tap per level; output = neg + diff*code/32
   genvar g;
   generate
      for (g = 0; g < LDC_LEVELS; g++) begin : g_tap
         assign tap[g] = active && (code == 5'(g));
      end
   endgenerate
endmodule : ldc_tap_decode
`default_nettype wire

/* File: hw/ldc_pin_ctrl.sv */
`default_nettype none
module ldc_pin_ctrl
   import ldc_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  rst_n,
   input  wire logic  route,
   input  wire logic  pin_in,
   output logic       pin_read
);
   typedef struct packed {
      logic s1;
      logic s2;
   } ldc_sync_type;
   ldc_sync_type st_r, st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // detector forced off while the level drives the pin
   assign pin_read = route ? 1'b0 : st_r.s2;
endmodule : ldc_pin_ctrl
`default_nettype wire

/* File: hw/ldc_top.sv */
// The register offsets and strobed register access are this design's own decisions.
`default_nettype none
module ldc_top
   import ldc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       sleep_wake,
   input  wire logic       pin_in,
   output logic            pin_read,
   output logic            analog_output_pin_connect,
   output logic            pin_dig_drv_off,
   output logic            pin_dig_in_off,
   output logic            src_pos_connect,
   output logic            src_neg_connect,
   output logic            src_neg_to_ground,
   output logic            sel_supply,
   output logic            sel_ext_ref,
   output logic            sel_fixed_reference,
   output logic      [31:0] tap_select,
   output logic            clamp_pos,
   output logic            clamp_neg
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0]    main;
      logic [7:0]    level;
      logic [7:0]    rdata;
      ldc_ladder_type lad;
      ldc_pin_type   pin;
   } ldc_state_type;

   ldc_state_type st_r, st_nxt;
   ldc_cfg_type   cfg;
   logic [31:0]   tap_w;
   logic          ladder_on;
   ldc_mode_type  mode;

   assign cfg.converter_enable        = st_r.main[LDC_BIT_ENABLE];
   assign cfg.low_power_source_select = st_r.main[LDC_BIT_LPS];
   assign cfg.pin_output_enable       = st_r.main[LDC_BIT_PIN_OE];
   assign cfg.positive_source_select  =
      st_r.main[LDC_BIT_PSS_HI:LDC_BIT_PSS_LO];
   assign cfg.level_code = st_r.level[LDC_LEVEL_W-1:0];

   assign ladder_on = cfg.converter_enable;

   ////////////////////////////////////////////////////////////////////////
   // mode decode; disabled codes other than the clamp ones leave ladder idle
   always_comb begin
      if (cfg.converter_enable) begin
         mode = LDC_MODE_LADDER;
      end else if (cfg.low_power_source_select &&
                   cfg.level_code == LDC_CODE_TOP) begin
         mode = LDC_MODE_CLAMP_POS;
      end else if (!cfg.low_power_source_select &&
                   cfg.level_code == LDC_CODE_BOT) begin
         mode = LDC_MODE_CLAMP_NEG;
      end else begin
         mode = LDC_MODE_OFF;
      end
   end

   ldc_tap_decode u_tap (
      .code   (cfg.level_code),
      .active (ladder_on),
      .tap    (tap_w)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      // sleep_wake only marks a wake; no field is touched by it
      if (wr && addr == LDC_ADDR_CTRL_MAIN) begin
         st_nxt.main = wdata & LDC_MAIN_MASK;
      end
      if (wr && addr == LDC_ADDR_LEVEL_SEL) begin
         st_nxt.level = wdata & LDC_LEVEL_MASK;
      end
      if (sleep_wake) begin
         st_nxt.main = st_nxt.main;
      end

      st_nxt.rdata = 8'h00;
      if (rd) begin
         case (addr)
            LDC_ADDR_CTRL_MAIN: st_nxt.rdata = st_r.main;
            LDC_ADDR_LEVEL_SEL: st_nxt.rdata = st_r.level;
            LDC_ADDR_STATUS: begin
               st_nxt.rdata = {6'h00, mode};
            end
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      st_nxt.lad.mode       = mode;
      st_nxt.lad.tap_onehot = tap_w;
      // disabled: one source is always cut for low power
      st_nxt.lad.src_neg_connect =
         ladder_on || !cfg.low_power_source_select;
      st_nxt.lad.src_pos_connect =
         ladder_on || cfg.low_power_source_select;
      st_nxt.lad.sel_supply =
         cfg.positive_source_select == LDC_PSS_SUPPLY;
      st_nxt.lad.sel_ext_ref =
         cfg.positive_source_select == LDC_PSS_EXT_REF;
      st_nxt.lad.sel_fixed_reference =
         cfg.positive_source_select == LDC_PSS_FIXED;

      st_nxt.pin.route_to_pin = cfg.pin_output_enable;
      st_nxt.pin.dig_drv_off  = cfg.pin_output_enable;
      st_nxt.pin.dig_in_off   = cfg.pin_output_enable;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_r       <= '0;
         st_r.main  <= LDC_MAIN_RST;
         st_r.level <= LDC_LEVEL_RST;
         st_r.lad.src_neg_connect <= 1'b1;
         st_r.lad.sel_supply      <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   ldc_pin_ctrl u_pin (
      .clock    (clock),
      .rst_n    (rst_n),
      .route    (st_r.pin.dig_in_off),
      .pin_in   (pin_in),
      .pin_read (pin_read)
   );

   assign rdata                     = st_r.rdata;
   assign analog_output_pin_connect = st_r.pin.route_to_pin;
   assign pin_dig_drv_off           = st_r.pin.dig_drv_off;
   assign pin_dig_in_off            = st_r.pin.dig_in_off;
   assign src_pos_connect           = st_r.lad.src_pos_connect;
   assign src_neg_connect           = st_r.lad.src_neg_connect;
   assign src_neg_to_ground         = 1'b1;
   assign sel_supply                = st_r.lad.sel_supply;
   assign sel_ext_ref               = st_r.lad.sel_ext_ref;
   assign sel_fixed_reference       = st_r.lad.sel_fixed_reference;
   assign tap_select                = st_r.lad.tap_onehot;
   assign clamp_pos = st_r.lad.mode == LDC_MODE_CLAMP_POS;
   assign clamp_neg = st_r.lad.mode == LDC_MODE_CLAMP_NEG;
endmodule : ldc_top
`default_nettype wire

/* File: test/ldc_assertions.sv */
`default_nettype none
module ldc_assertions
   import ldc_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [1:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic        pin_read,
   input wire logic        analog_output_pin_connect,
   input wire logic        pin_dig_drv_off,
   input wire logic        pin_dig_in_off,
   input wire logic        sel_supply,
   input wire logic        sel_ext_ref,
   input wire logic        sel_fixed_reference,
   input wire logic [31:0] tap_select
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic wm;
   // a second main write in the next cycle would move the outputs only after the check, yet is still excluded
   assign wm = wr && addr == LDC_ADDR_CTRL_MAIN;
   a_tap_off_disabled: assert property (
      wm && !wdata[LDC_BIT_ENABLE] ##1 !wm |=> tap_select == 32'h0)
      else $error("tap active while disabled");
   a_tap_single_level: assert property ($onehot0(tap_select))
      else $error("more than one tap");
   a_pin_route: assert property (
      wm ##1 !wm |=>
         analog_output_pin_connect == $past(wdata[LDC_BIT_PIN_OE], 2))
      else $error("pin route differs from write");
   a_pin_digital_off: assert property (
      analog_output_pin_connect |-> pin_dig_drv_off && pin_dig_in_off)
      else $error("digital pin logic left on");
   a_pin_read_zero: assert property (
      analog_output_pin_connect |-> !pin_read)
      else $error("routed pin reads one");
   a_source_onehot: assert property (
      $onehot0({sel_supply, sel_ext_ref, sel_fixed_reference}))
      else $error("two sources selected");
   a_reset_clear: assert property (
      $rose(rst_n) |-> tap_select == 32'h0 && !analog_output_pin_connect)
      else $error("outputs not cleared by reset");
   a_reserved_zero: assert property (
      rd && addr == LDC_ADDR_LEVEL_SEL |=> rdata[7:5] == 3'h0)
      else $error("reserved level bits read one");
endmodule : ldc_assertions
bind ldc_top ldc_assertions u_chk (
   .clock                     (clock),
   .rst_n                     (rst_n),
   .addr                      (addr),
   .wdata                     (wdata),
   .wr                        (wr),
   .rd                        (rd),
   .rdata                     (rdata),
   .pin_read                  (pin_read),
   .analog_output_pin_connect (analog_output_pin_connect),
   .pin_dig_drv_off           (pin_dig_drv_off),
   .pin_dig_in_off            (pin_dig_in_off),
   .sel_supply                (sel_supply),
   .sel_ext_ref               (sel_ext_ref),
   .sel_fixed_reference       (sel_fixed_reference),
   .tap_select                (tap_select)
);
`default_nettype wire

/* File: test/ldc_top_tb.sv */
`default_nettype none
module ldc_top_tb
   import ldc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst_n = 0, wr = 0, rd = 0, sleep_wake = 0, pin_in = 0;
   logic [1:0] addr = 0;
   logic [7:0] wdata = 0, rdata;
   logic [31:0] tap_select;
   logic pin_read, analog_output_pin_connect, pin_dig_drv_off, pin_dig_in_off;
   logic src_pos_connect, src_neg_connect, src_neg_to_ground, clamp_pos;
   logic sel_supply, sel_ext_ref, sel_fixed_reference, clamp_neg;
   int fail_count = 0, total_checks = 0;
   ldc_top uut (
      .clock                     (clock),
      .rst_n                     (rst_n),
      .addr                      (addr),
      .wdata                     (wdata),
      .wr                        (wr),
      .rd                        (rd),
      .rdata                     (rdata),
      .sleep_wake                (sleep_wake),
      .pin_in                    (pin_in),
      .pin_read                  (pin_read),
      .analog_output_pin_connect (analog_output_pin_connect),
      .pin_dig_drv_off           (pin_dig_drv_off),
      .pin_dig_in_off            (pin_dig_in_off),
      .src_pos_connect           (src_pos_connect),
      .src_neg_connect           (src_neg_connect),
      .src_neg_to_ground         (src_neg_to_ground),
      .sel_supply                (sel_supply),
      .sel_ext_ref               (sel_ext_ref),
      .sel_fixed_reference       (sel_fixed_reference),
      .tap_select                (tap_select),
      .clamp_pos                 (clamp_pos),
      .clamp_neg                 (clamp_neg)
   );
   always #4 clock = ~clock;
   ////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // waits two more edges so the lagging outputs have settled
   task wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask : wreg
   task rchk(input logic [1:0] a, input logic [7:0] e);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk(32'(rdata), 32'(e));
   endtask : rchk
   ////////////////////////////////////////////////////////////
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      rchk(LDC_ADDR_CTRL_MAIN, 8'h00);
      rchk(LDC_ADDR_LEVEL_SEL, 8'h00);
      chk(32'({clamp_neg, analog_output_pin_connect}), 32'h2);
      rchk(LDC_ADDR_STATUS, 8'(LDC_MODE_CLAMP_NEG));
      wreg(LDC_ADDR_CTRL_MAIN, 8'hff);
      rchk(LDC_ADDR_CTRL_MAIN, 8'hec);
      wreg(LDC_ADDR_LEVEL_SEL, 8'hff);
      rchk(LDC_ADDR_LEVEL_SEL, 8'h1f);
      rchk(LDC_ADDR_STATUS, 8'(LDC_MODE_LADDER));
      rchk(2'h3, 8'h00);
      for (int p = 0; p < 3; p++) begin
         wreg(LDC_ADDR_CTRL_MAIN, 8'(8'h80 | (p << 2)));
         chk(32'({sel_supply, sel_ext_ref, sel_fixed_reference}),
             32'(3'h4 >> p));
         chk(32'(src_neg_to_ground), 32'h1);
      end
      for (int i = 0; i < 32; i++) begin
         wreg(LDC_ADDR_LEVEL_SEL, 8'(i));
         chk(tap_select, 32'h1 << i);
      end
      wreg(LDC_ADDR_CTRL_MAIN, 8'h48);
      chk(32'({clamp_pos, clamp_neg,
          src_pos_connect, src_neg_connect}), 32'ha);
      chk(tap_select, 32'h0);
      rchk(LDC_ADDR_STATUS, 8'(LDC_MODE_CLAMP_POS));
      wreg(LDC_ADDR_CTRL_MAIN, 8'h00);
      // code 11111 with lps clear is no clamp code: ladder stays idle
      rchk(LDC_ADDR_STATUS, 8'(LDC_MODE_OFF));
      chk(32'({clamp_pos, clamp_neg}), 32'h0);
      wreg(LDC_ADDR_LEVEL_SEL, 8'h00);
      chk(32'({clamp_pos, clamp_neg,
          src_pos_connect, src_neg_connect}), 32'h5);
      @(posedge clock);
      pin_in <= 1'b1;
      wreg(LDC_ADDR_CTRL_MAIN, 8'h20);
      chk(32'({analog_output_pin_connect,
          pin_dig_drv_off, pin_dig_in_off, pin_read}), 32'he);
      // converter disabled before sleep to keep sleep current low
      wreg(LDC_ADDR_CTRL_MAIN, 8'h68);
      @(posedge clock);
      sleep_wake <= 1'b1;
      @(posedge clock);
      sleep_wake <= 1'b0;
      rchk(LDC_ADDR_CTRL_MAIN, 8'h68);
      chk(32'(analog_output_pin_connect), 32'h1);
      wreg(LDC_ADDR_CTRL_MAIN, 8'h00);
      chk(32'({analog_output_pin_connect, pin_read}), 32'h1);
      wreg(LDC_ADDR_LEVEL_SEL, 8'h15);
      wreg(LDC_ADDR_CTRL_MAIN, 8'ha0);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rchk(LDC_ADDR_CTRL_MAIN, 8'h00);
      rchk(LDC_ADDR_LEVEL_SEL, 8'h00);
      chk(32'(analog_output_pin_connect), 32'h0);
      chk(tap_select, 32'h0);
      summarize();
   end
endmodule : ldc_top_tb
`default_nettype wire
